// ---- logic/sgde_pkg.sv ----
// Constants, register map and state types of the descriptor engine
//
// Contract
// - Control word read from descriptor offsets 4-7
// - Control bit 0 requests status report write
// - Control bit 4 raises interrupt when done
// - Control bit 5 raises interrupt on error
// - Control bit 6 raises interrupt on end-of-packet
// - Control bits 31:8 give page length in bytes
// - Next pointer at 8-15, 32-byte aligned
// - Pointer bit 4 flags next descriptor ready
// - Condition bit 0 ends chain after descriptor
// - Condition bit 1 aborts descriptor on error
// - Condition bit 3 waits for start-of-packet
// - Source address at 16-23, low word first
// - Destination address at 24-31, low word first
// - Report word: count, flags, processed size
package sgde_pkg;
  // Software register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] REG_HEAD_LO = 5'h08;
  localparam logic [4:0] REG_HEAD_HI = 5'h0C;
  localparam logic [4:0] REG_CUR_LO = 5'h10;
  localparam logic [4:0] REG_CUR_HI = 5'h14;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_CNT_LO = 4;
  localparam logic [63:0] HEAD_RST = 64'h0;
  // Descriptor word indices (byte offset / 4)
  localparam logic [2:0] DW_REPORT = 3'h0;
  localparam logic [2:0] DW_CTRL = 3'h1;
  localparam logic [2:0] DW_NEXT_LO = 3'h2;
  localparam logic [2:0] DW_NEXT_HI = 3'h3;
  localparam logic [2:0] DW_SRC_LO = 3'h4;
  localparam logic [2:0] DW_SRC_HI = 3'h5;
  localparam logic [2:0] DW_DST_LO = 3'h6;
  localparam logic [2:0] DW_DST_HI = 3'h7;
  localparam logic [63:0] WORD_STEP = 64'h4;
  // Control word fields
  localparam int CW_REPORT = 0;
  localparam int CW_IRQ_DONE = 4;
  localparam int CW_IRQ_ERR = 5;
  localparam int CW_IRQ_EOP = 6;
  localparam int CW_LEN_LO = 8;
  // Low pointer word fields
  localparam int NP_READY = 4;
  localparam int NP_ADDR_LO = 5;
  localparam int SE_END = 0;
  localparam int SE_ABORT = 1;
  localparam int SE_SOP = 3;
  // Report word fields
  localparam int RW_DONE = 4;
  localparam int RW_ERR = 5;
  localparam int RW_EOP = 6;
  localparam int RW_SIZE_LO = 8;
  localparam int LEN_W = 24;
  localparam int CMD_W = 152;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_SOP_WAIT,
    ST_ISSUE,
    ST_XFER,
    ST_REPORT,
    ST_CHAIN,
    ST_POLL
  } sgde_state_t;
endpackage

// ---- logic/sgde_engine.sv ----
// Scatter-gather descriptor engine with Avalon-MM register slave
module sgde_engine (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_mem_read,
  output logic o_mem_write,
  output logic [63:0] o_mem_address,
  output logic [31:0] o_mem_writedata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_readdata,
  output logic o_move_valid,
  input wire logic i_move_ready,
  output logic [63:0] o_move_src,
  output logic [63:0] o_move_dst,
  output logic [23:0] o_move_len,
  output logic o_move_abort,
  input wire logic i_move_done,
  input wire logic i_move_err,
  input wire logic i_move_eop,
  input wire logic [23:0] i_move_bytes,
  input wire logic i_src_sop,
  output logic o_irq,
  output logic o_busy
);
  typedef struct packed {
    sgde_pkg::sgde_state_t state;
    logic resp;
    logic [31:0] rdata;
    logic busy;
    logic done;
    logic err_seen;
    logic [63:0] head;
    logic [63:0] cur;
    logic [2:0] idx;
    logic [7:0][31:0] w;
    logic [3:0] cnt;
    logic xerr;
    logic xeop;
    logic [23:0] xbytes;
    logic irq;
    logic abort;
    logic mem_rd;
    logic mem_wr;
    logic [63:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [1:0][sgde_pkg::CMD_W-1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] fcnt;
  } sgde_state_reg_t;

  sgde_state_reg_t r_reg;
  sgde_state_reg_t r_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic req;
  logic push;
  logic pop;
  logic [63:0] next_ptr;
  logic [31:0] ctrl_w;
  logic [31:0] np_w;
  logic err_now;
  logic eop_now;
  logic [sgde_pkg::CMD_W-1:0] cmd_head;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign req = i_avs_read | i_avs_write;
  assign ctrl_w = r_reg.w[sgde_pkg::DW_CTRL];
  assign np_w = r_reg.w[sgde_pkg::DW_NEXT_LO];
  assign next_ptr = {r_reg.w[sgde_pkg::DW_NEXT_HI],
                     np_w[31:sgde_pkg::NP_ADDR_LO], 5'h00};
  assign push = (r_reg.state == sgde_pkg::ST_ISSUE) &&
                (r_reg.fcnt != 2'(sgde_pkg::BUF_DEPTH));
  assign pop = o_move_valid & i_move_ready;
  assign err_now = i_move_err | r_reg.xerr;
  assign eop_now = i_move_eop | r_reg.xeop;

  always_comb begin
    r_next = r_reg;
    r_next.irq = 1'b0;
    r_next.abort = 1'b0;
    // Register slave: one wait cycle, answer on second edge
    r_next.resp = req & ~r_reg.resp;
    if (req && !r_reg.resp) begin
      r_next.rdata = 32'h0;
      if (i_avs_read) begin
        if (i_avs_address == sgde_pkg::REG_STAT) begin
          r_next.rdata[sgde_pkg::STAT_BUSY] = r_reg.busy;
          r_next.rdata[sgde_pkg::STAT_DONE] = r_reg.done;
          r_next.rdata[sgde_pkg::STAT_ERR] = r_reg.err_seen;
          r_next.rdata[sgde_pkg::STAT_CNT_LO +: 4] = r_reg.cnt;
        end else if (i_avs_address == sgde_pkg::REG_HEAD_LO) begin
          r_next.rdata = r_reg.head[31:0];
        end else if (i_avs_address == sgde_pkg::REG_HEAD_HI) begin
          r_next.rdata = r_reg.head[63:32];
        end else if (i_avs_address == sgde_pkg::REG_CUR_LO) begin
          r_next.rdata = r_reg.cur[31:0];
        end else if (i_avs_address == sgde_pkg::REG_CUR_HI) begin
          r_next.rdata = r_reg.cur[63:32];
        end
      end
    end
    if (i_avs_write && r_reg.resp) begin
      if (i_avs_address == sgde_pkg::REG_HEAD_LO) begin
        r_next.head[31:0] = merge_be(r_reg.head[31:0], i_avs_writedata,
                                     i_avs_byteenable);
      end else if (i_avs_address == sgde_pkg::REG_HEAD_HI) begin
        r_next.head[63:32] = merge_be(r_reg.head[63:32], i_avs_writedata,
                                      i_avs_byteenable);
      end else if (i_avs_address == sgde_pkg::REG_CTRL) begin
        if (i_avs_byteenable[0] && i_avs_writedata[sgde_pkg::CTRL_START]
            && !r_reg.busy) begin
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.err_seen = 1'b0;
          r_next.cur = {r_reg.head[63:5], 5'h00};
          r_next.mem_addr = {r_reg.head[63:5], 5'h00} + sgde_pkg::WORD_STEP;
          r_next.idx = sgde_pkg::DW_CTRL;
          r_next.mem_rd = 1'b1;
          r_next.state = sgde_pkg::ST_FETCH;
        end
      end
    end
    // Command buffer: two entries, back-pressure stalls the issue state
    if (push) begin
      r_next.fifo[r_reg.wp] = {
        r_reg.w[sgde_pkg::DW_SRC_HI], r_reg.w[sgde_pkg::DW_SRC_LO],
        r_reg.w[sgde_pkg::DW_DST_HI], r_reg.w[sgde_pkg::DW_DST_LO],
        ctrl_w[31:sgde_pkg::CW_LEN_LO]};
      r_next.wp = ~r_reg.wp;
    end
    if (pop) begin
      r_next.rp = ~r_reg.rp;
    end
    r_next.fcnt = r_reg.fcnt + 2'(push) - 2'(pop);
    case (r_reg.state)
      sgde_pkg::ST_IDLE: begin
        r_next.mem_rd = r_next.mem_rd;
      end
      sgde_pkg::ST_FETCH: begin
        if (i_mem_ack) begin
          r_next.w[r_reg.idx] = i_mem_readdata;
          if (r_reg.idx == sgde_pkg::DW_DST_HI) begin
            r_next.mem_rd = 1'b0;
            r_next.xerr = 1'b0;
            r_next.xeop = 1'b0;
            r_next.xbytes = 24'h0;
            if (np_w[sgde_pkg::SE_SOP]) begin
              r_next.state = sgde_pkg::ST_SOP_WAIT;
            end else begin
              r_next.state = sgde_pkg::ST_ISSUE;
            end
          end else begin
            r_next.idx = r_reg.idx + 3'h1;
            r_next.mem_addr = r_reg.mem_addr + sgde_pkg::WORD_STEP;
          end
        end
      end
      sgde_pkg::ST_SOP_WAIT: begin
        if (i_src_sop) begin
          r_next.state = sgde_pkg::ST_ISSUE;
        end
      end
      sgde_pkg::ST_ISSUE: begin
        if (push) begin
          r_next.state = sgde_pkg::ST_XFER;
        end
      end
      sgde_pkg::ST_XFER: begin
        if (i_move_eop) begin
          r_next.xeop = 1'b1;
        end
        if (i_move_err) begin
          r_next.xerr = 1'b1;
        end
        if (i_move_done || (i_move_err && np_w[sgde_pkg::SE_ABORT])) begin
          r_next.abort = ~i_move_done;
          if (!i_move_done) begin
            r_next.fcnt = 2'h0;
            r_next.rp = r_reg.wp;
          end
          r_next.xbytes = i_move_bytes;
          r_next.cnt = r_reg.cnt + 4'h1;
          r_next.irq = ctrl_w[sgde_pkg::CW_IRQ_DONE]
            | (ctrl_w[sgde_pkg::CW_IRQ_ERR] & err_now)
            | (ctrl_w[sgde_pkg::CW_IRQ_EOP] & eop_now);
          r_next.err_seen = r_reg.err_seen | err_now;
          if (ctrl_w[sgde_pkg::CW_REPORT]) begin
            r_next.mem_wr = 1'b1;
            r_next.mem_addr = r_reg.cur;
            // Report word built field by field, bit 7 stays zero
            r_next.mem_wdata = 32'h0;
            r_next.mem_wdata[3:0] = r_reg.cnt + 4'h1;
            r_next.mem_wdata[sgde_pkg::RW_DONE] = 1'b1;
            r_next.mem_wdata[sgde_pkg::RW_ERR] = err_now;
            r_next.mem_wdata[sgde_pkg::RW_EOP] = eop_now;
            r_next.mem_wdata[sgde_pkg::RW_SIZE_LO +: sgde_pkg::LEN_W] =
              i_move_bytes;
            r_next.state = sgde_pkg::ST_REPORT;
          end else begin
            r_next.state = sgde_pkg::ST_CHAIN;
          end
        end
      end
      sgde_pkg::ST_REPORT: begin
        if (i_mem_ack) begin
          r_next.mem_wr = 1'b0;
          r_next.state = sgde_pkg::ST_CHAIN;
        end
      end
      sgde_pkg::ST_CHAIN: begin
        if (np_w[sgde_pkg::SE_END]) begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.state = sgde_pkg::ST_IDLE;
        end else if (np_w[sgde_pkg::NP_READY]) begin
          r_next.cur = next_ptr;
          r_next.mem_addr = next_ptr + sgde_pkg::WORD_STEP;
          r_next.idx = sgde_pkg::DW_CTRL;
          r_next.mem_rd = 1'b1;
          r_next.state = sgde_pkg::ST_FETCH;
        end else begin
          r_next.mem_addr = r_reg.cur + 64'({sgde_pkg::DW_NEXT_LO, 2'h0});
          r_next.mem_rd = 1'b1;
          r_next.state = sgde_pkg::ST_POLL;
        end
      end
      sgde_pkg::ST_POLL: begin
        if (i_mem_ack) begin
          r_next.w[sgde_pkg::DW_NEXT_LO] = i_mem_readdata;
          r_next.mem_rd = 1'b0;
          r_next.state = sgde_pkg::ST_CHAIN;
        end
      end
      default: begin
        r_next.state = sgde_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: sgde_pkg::ST_IDLE, head: sgde_pkg::HEAD_RST,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_avs_waitrequest = req & ~r_reg.resp;
  assign o_avs_readdata = r_reg.rdata;
  assign o_mem_read = r_reg.mem_rd;
  assign o_mem_write = r_reg.mem_wr;
  assign o_mem_address = r_reg.mem_addr;
  assign o_mem_writedata = r_reg.mem_wdata;
  assign o_move_valid = (r_reg.fcnt != 2'h0);
  assign cmd_head = r_reg.fifo[r_reg.rp];
  assign o_move_src = cmd_head[sgde_pkg::CMD_W-1 -: 64];
  assign o_move_dst = cmd_head[sgde_pkg::LEN_W +: 64];
  assign o_move_len = cmd_head[sgde_pkg::LEN_W-1:0];
  assign o_move_abort = r_reg.abort;
  assign o_irq = r_reg.irq;
  assign o_busy = r_reg.busy;
endmodule

// ---- verif/sgde_mem_model.sv ----
// Host memory and page mover on the far side of the engine
module sgde_mem_model (
  input wire logic i_clk,
  input wire logic i_err,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [63:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [23:0] i_len,
  output logic o_done,
  output logic o_fail,
  output logic [23:0] o_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:127];
  logic [1:0] wt = 0;
  logic [2:0] mv = 0;
  logic seen = 0;
  initial begin
    {o_ack, o_done, o_fail, o_rdata, o_bytes} = '0;
  end
  assign o_ready = (mv == 0) && seen; // Stalls one cycle per command
  always @(posedge i_clk) begin
    seen <= i_valid && (mv == 3'h0) && !seen;
    o_ack <= 1'b0;
    o_done <= 1'b0;
    o_fail <= 1'b0;
    o_rdata <= ~o_rdata; // Read data is not held past the ack
    if ((i_rd || i_wr) && !o_ack) begin
      wt <= wt + 2'h1;
      if (wt == 2'h2) begin
        wt <= 2'h0;
        o_ack <= 1'b1;
        o_rdata <= mem[i_addr[8:2]];
        if (i_wr) mem[i_addr[8:2]] <= i_wdata;
      end
    end
    if (i_valid && o_ready) begin
      o_bytes <= i_len;
      mv <= 3'h1;
    end else if (mv == 3'h4) begin
      mv <= 3'h0;
      o_done <= !i_err;
      o_fail <= i_err;
    end else if (mv != 3'h0) mv <= mv + 3'h1;
  end
endmodule

// ---- verif/sgde_engine_checker.sv ----
// Protocol checker bound to the engine ports
module sgde_engine_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_avs_read,
  input wire logic o_avs_waitrequest,
  input wire logic o_mem_read,
  input wire logic o_mem_write,
  input wire logic [63:0] o_mem_address,
  input wire logic [31:0] o_mem_writedata,
  input wire logic i_mem_ack,
  input wire logic o_move_valid,
  input wire logic i_move_ready,
  input wire logic [63:0] o_move_src,
  input wire logic o_irq,
  input wire logic o_move_abort,
  input wire logic i_move_done,
  input wire logic i_move_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd_held;
    o_mem_read && !i_mem_ack;
  endsequence
  sequence s_ctrl_ack;
    o_mem_read && i_mem_ack && o_mem_address[4:0] == 5'h04;
  endsequence
  a_wait_one: assert property (i_avs_read && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  a_rd_stable: assert property (s_rd_held |=> o_mem_read
    && $stable(o_mem_address)) else $error("fetch dropped");
  a_word_step: assert property (s_ctrl_ack |=> o_mem_read
    && o_mem_address[4:0] == 5'h08) else $error("fetch order");
  a_fetch_align: assert property (o_mem_read
    |-> o_mem_address[1:0] == 2'h0) else $error("fetch align");
  a_report_fmt: assert property (o_mem_write |->
    o_mem_address[4:0] == 5'h00 && o_mem_writedata[4]
    && !o_mem_writedata[7]) else $error("report format");
  a_irq_cause: assert property (o_irq
    |-> $past(i_move_done) || $past(i_move_err)) else $error("irq cause");
  a_irq_pulse: assert property (o_irq |=> !o_irq)
    else $error("irq width");
  a_abort_cause: assert property (o_move_abort
    |-> $past(i_move_err)) else $error("abort cause");
  a_cmd_hold: assert property (o_move_valid && !i_move_ready
    |=> o_move_valid && $stable(o_move_src)) else $error("cmd lost");
endmodule
bind sgde_engine sgde_engine_checker sgde_engine_checker_i (.i_clk,
  .i_resetn, .i_avs_read, .o_avs_waitrequest, .o_mem_read, .o_mem_write,
  .o_mem_address, .o_mem_writedata, .i_mem_ack, .o_move_valid,
  .i_move_ready, .o_move_src, .o_irq, .o_move_abort, .i_move_done,
  .i_move_err);

// ---- verif/tb_sgde_engine.sv ----
// Self-checking bench for the descriptor engine
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
`define M sgde_mem_model_i.mem
module tb_sgde_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, err = 0, sop = 0, eop = 0;
  logic ack, rdy, done, fail, wt_r, mr, mw, mv, ab, irq, busy;
  logic [3:0] be = 4'hF;
  logic [4:0] ad = 0;
  logic [31:0] wd = 0, q, rdat, mrd, mwd;
  logic [63:0] ma, src, dst;
  logic [23:0] len, byt;
  logic [63:0] cs[$], cd[$];
  logic [23:0] cl[$];
  int n_errors = 0, n_tests = 0, n_irq = 0, n_ab = 0;
  always #2.5 clk = ~clk;
  sgde_engine sgde_engine_i (.i_clk(clk), .i_resetn(rstn),
    .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt_r), .o_mem_read(mr), .o_mem_write(mw),
    .o_mem_address(ma), .o_mem_writedata(mwd), .i_mem_ack(ack),
    .i_mem_readdata(mrd), .o_move_valid(mv), .i_move_ready(rdy),
    .o_move_src(src), .o_move_dst(dst), .o_move_len(len),
    .o_move_abort(ab), .i_move_done(done), .i_move_err(fail),
    .i_move_eop(eop), .i_move_bytes(byt), .i_src_sop(sop), .o_irq(irq),
    .o_busy(busy));
  sgde_mem_model sgde_mem_model_i (.i_clk(clk), .i_err(err), .i_rd(mr),
    .i_wr(mw), .i_addr(ma), .i_wdata(mwd), .o_ack(ack), .o_rdata(mrd),
    .i_valid(mv), .o_ready(rdy), .i_len(len), .o_done(done),
    .o_fail(fail), .o_bytes(byt));
  always @(posedge clk) begin
    if (irq) n_irq++;
    if (ab) n_ab++;
    if (mv && rdy) begin
      cs.push_back(src);
      cd.push_back(dst);
      cl.push_back(len);
    end
  end
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wt_r);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (3) @(posedge clk);
    while (busy && k < 600) begin
      @(posedge clk);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic put(input int b, input logic [31:0] c, n, s, t);
    `M[b] = 32'hFFFF_FFFF;
    `M[b + 1] = c;
    `M[b + 2] = n;
    `M[b + 3] = 32'h0;
    `M[b + 4] = s;
    `M[b + 5] = 32'h0;
    `M[b + 6] = t;
    `M[b + 7] = 32'h0;
  endtask
  task automatic go(input logic [31:0] h);
    bus(1'b1, 5'h08, h);
    bus(1'b1, 5'h0C, 32'h0);
    bus(1'b1, 5'h00, 32'h1);
  endtask
  task automatic t_regs;
    bus(1'b1, 5'h0C, 32'h0000_00A5);
    bus(1'b0, 5'h0C, 32'h0);
    `CHK(q, 32'h0000_00A5)
    bus(1'b0, 5'h18, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_chain;
    put(8'h40, 32'h0000_4011, 32'h0000_0120, 32'h1000, 32'h2000);
    put(8'h48, 32'h0000_2000, 32'h0000_0001, 32'h3000, 32'h4000);
    go(32'h0000_0100);
    repeat (80) @(posedge clk);
    `CHK(cs.size(), 1)
    `M[8'h42] = 32'h0000_0130;
    wait_idle;
    `CHK(`M[8'h40][31:4], 28'h0000401)
    `CHK(`M[8'h48], 32'hFFFF_FFFF)
    `CHK(n_irq, 1)
    `CHK(cs.size(), 2)
    `CHK(cs[0], 64'h1000)
    `CHK(cd[1], 64'h4000)
    `CHK(cs[1], 64'h3000)
    `CHK(cl[0], 24'h40)
    bus(1'b0, 5'h04, 32'h0);
    `CHK(q[1:0], 2'h2)
  endtask
  task automatic t_abort;
    put(8'h60, 32'h0000_1021, 32'h0000_0003, 32'h5000, 32'h6000);
    err <= 1'b1;
    go(32'h0000_0180);
    wait_idle;
    err <= 1'b0;
    `CHK(n_ab, 1)
    `CHK(n_irq, 2)
    `CHK(`M[8'h60][5:4], 2'h3)
  endtask
  task automatic t_sop;
    put(8'h70, 32'h0000_0841, 32'h0000_0009, 32'h7000, 32'h8000);
    go(32'h0000_01C0);
    repeat (60) @(posedge clk);
    `CHK(cs.size(), 3)
    sop <= 1'b1;
    eop <= 1'b1;
    @(posedge clk);
    sop <= 1'b0;
    wait_idle;
    eop <= 1'b0;
    `CHK(cl[3], 24'h8)
    `CHK(n_irq, 3)
    `CHK(`M[8'h70], 32'h0000_0854)
  endtask
  task automatic give_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_chain;
    t_abort;
    t_sop;
    give_verdict;
  end
  initial begin
    #40000;
    n_errors++;
    give_verdict;
  end
endmodule
